// ### core/pcrs_core.v
`timescale 1ns/100ps
`include "pcrs_map.vh"
// Overview of operation
// [RQ1] 21-bit counter, 2-Mbyte space, unimplemented fetches return zero
// [RQ2] start at 0000h; vectors 0008h high, 0018h low
// [RQ3] counter as three bytes, upper bytes via latches
// [RQ4] low byte write loads both latches into counter
// [RQ5] low byte read copies upper bytes into latches
// [RQ6] bit 0 forced zero, fetch steps by two
// [RQ7] calls, jumps, branches load counter, ignore latches
// [RQ8] push on call/interrupt, pop on returns, latches untouched
// [RQ9] 31 entries of 21 bits, 5-bit pointer
// [RQ10] push increments then writes; pop reads then decrements
// [RQ11] every reset clears pointer; zero holds no entry
// [RQ12] top entry and pointer readable and writable
// [RQ13] fault reset on: 31st push stores, flags, resets
// [RQ14] fault reset off: pointer sticks at 31
// [RQ15] empty pop loads zero, flags underflow, pointer stays
// [RQ16] fault reset option gates device reset on faults
// [RQ17] flags cleared only by software zero or power-on
// [RQ18] software push stores counter; software pop only decrements
// [RQ19] full bit 7, underflow bit 6, bit 5 zero
// [RQ20] hidden shadow loaded on vectoring, restored by fast return
// [RQ21] fast call saves shadow, fast return restores it
// [RQ22] software masks interrupts around top entry access
// [RQ23] pointer writes take effect immediately
module pcrs_core (
  input wire aclk,
  input wire aresetn,
  input wire por_n,
  input wire stack_fault_reset_enable,
  input wire [20:0] prog_mem_limit,
  input wire fetch_advance,
  input wire [20:0] fetch_return_addr,
  input wire op_call,
  input wire op_fast,
  input wire op_jump,
  input wire [20:0] jump_target,
  input wire op_return,
  input wire op_literal_return,
  input wire op_interrupt_return,
  input wire op_sw_push,
  input wire op_sw_pop,
  input wire irq_ack,
  input wire irq_high,
  input wire [7:0] status_in,
  input wire [7:0] working_register_in,
  input wire [7:0] bank_select_register_in,
  input wire [15:0] fetch_data_in,
  output reg [15:0] fetch_data,
  output reg [20:0] pc,
  output reg [7:0] status_restore,
  output reg [7:0] working_restore,
  output reg [7:0] bank_restore,
  output reg restore_valid,
  output reg device_reset_req,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// state
reg [20:0] stack_mem [0:`PCRS_DEPTH-1]; // [RQ9]
reg [4:0] stack_pointer_value;
reg stack_full_flag;
reg stack_underflow_flag;
reg [7:0] pc_high_holding_latch;
reg [4:0] pc_upper_holding_latch;
reg [7:0] shadow_status;
reg [7:0] shadow_working;
reg [7:0] shadow_bank;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg fault_pending;
reg fault_en_meta;
reg fault_en_mid;
reg fault_en_late;
reg fault_enable;
reg [31:0] rd_value;
reg rd_bad;

// entry zero is never written, so pointer zero must read as zero, not as an unwritten word
wire [20:0] top_entry = (stack_pointer_value == `PCRS_SP_EMPTY) ? 21'h00_0000 :
  stack_mem[stack_pointer_value];
wire [7:0] pc_low_byte = pc[7:0];
wire [7:0] pc_high_byte = pc[15:8];
wire [4:0] pc_upper_byte = pc[20:16];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite handshake
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire rd_go = s_axi_arvalid && s_axi_arready;
wire wr_lo = wr_go && w_strb[0];
wire wr_status = wr_lo && aw_addr == `PCRS_ADDR_STATUS;
wire wr_pcl = wr_lo && aw_addr == `PCRS_ADDR_PCL;
wire wr_lath = wr_lo && aw_addr == `PCRS_ADDR_LATH;
wire wr_latu = wr_lo && aw_addr == `PCRS_ADDR_LATU;
wire wr_top_entry_low = wr_lo && aw_addr == `PCRS_ADDR_TOP_ENTRY_LOW;
wire wr_top_entry_high = wr_lo && aw_addr == `PCRS_ADDR_TOP_ENTRY_HIGH;
wire wr_top_entry_upper = wr_lo && aw_addr == `PCRS_ADDR_TOP_ENTRY_UPPER;
wire wr_tos = wr_top_entry_low || wr_top_entry_high || wr_top_entry_upper;
wire rd_pcl = rd_go && s_axi_araddr == `PCRS_ADDR_PCL;

function wr_known;
  input [7:0] a;
  begin
    wr_known = a <= `PCRS_ADDR_CFG && a[1:0] == 2'b00;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// stack operations
wire push_req = op_call || irq_ack || op_sw_push; // [RQ8]
wire pop_req = op_return || op_literal_return || op_interrupt_return; // [RQ8]
wire stack_empty = stack_pointer_value == `PCRS_SP_EMPTY;
wire stack_at_top = stack_pointer_value == `PCRS_SP_LAST;
wire [4:0] sp_inc = stack_pointer_value + `PCRS_SP_ONE;
wire push_will_fill = sp_inc == `PCRS_SP_LAST;
// sw push stores the current counter; call/interrupt store the next instruction
wire [20:0] push_value = op_sw_push ? pc : fetch_return_addr; // [RQ18]

always @(posedge aclk) begin
  if (!aresetn) begin
    stack_pointer_value <= `PCRS_SP_EMPTY; // [RQ11]
    pc <= `PCRS_RESET_VEC; // [RQ2]
    pc_high_holding_latch <= 8'h00;
    pc_upper_holding_latch <= 5'h00;
    device_reset_req <= 1'b0;
    fault_pending <= 1'b0;
    restore_valid <= 1'b0;
    status_restore <= 8'h00;
    working_restore <= 8'h00;
    bank_restore <= 8'h00;
  end else if (fault_pending) begin
    // flag is already set; reset follows, pointer cleared
    device_reset_req <= 1'b1; // [RQ16]
    stack_pointer_value <= `PCRS_SP_EMPTY; // [RQ13]
    pc <= `PCRS_RESET_VEC;
    fault_pending <= 1'b0;
    restore_valid <= 1'b0;
  end else begin
    device_reset_req <= 1'b0;
    restore_valid <= 1'b0;
    if (irq_ack) begin
      pc <= irq_high ? `PCRS_HIGH_VEC : `PCRS_LOW_VEC; // [RQ2]
    end else if (op_call || op_jump) begin
      pc <= {jump_target[20:1], 1'b0}; // [RQ7]
    end else if (pop_req) begin
      pc <= stack_empty ? `PCRS_RESET_VEC : {top_entry[20:1], 1'b0}; // [RQ15]
    end else if (wr_pcl) begin
      pc <= {pc_upper_holding_latch, pc_high_holding_latch, w_data[7:1], 1'b0}; // [RQ4]
    end else if (fetch_advance) begin
      pc <= pc + `PCRS_PC_STEP; // [RQ6]
    end
    if (push_req) begin
      if (!stack_at_top) begin
        stack_pointer_value <= sp_inc; // [RQ10]
      end
      if (push_will_fill && fault_enable) begin
        fault_pending <= 1'b1; // [RQ13]
      end
    end else if (pop_req || op_sw_pop) begin
      if (!stack_empty) begin
        stack_pointer_value <= stack_pointer_value - `PCRS_SP_ONE; // [RQ10]
      end else if (pop_req && fault_enable) begin
        fault_pending <= 1'b1; // [RQ16]
      end
    end else if (wr_status) begin
      stack_pointer_value <= w_data[`PCRS_SP_MSB:0]; // [RQ23]
    end
    if (rd_pcl) begin
      pc_high_holding_latch <= pc_high_byte; // [RQ5]
      pc_upper_holding_latch <= pc_upper_byte; // [RQ5]
    end else if (wr_lath) begin
      pc_high_holding_latch <= w_data[7:0]; // [RQ3]
    end else if (wr_latu) begin
      pc_upper_holding_latch <= w_data[4:0]; // [RQ3]
    end
    if (op_interrupt_return && op_fast || op_return && op_fast) begin
      status_restore <= shadow_status; // [RQ20]
      working_restore <= shadow_working; // [RQ21]
      bank_restore <= shadow_bank;
      restore_valid <= 1'b1;
    end
  end
end

// stack storage: entry 0 is never written, so it holds no value
always @(posedge aclk) begin
  if (push_req && !stack_at_top && !fault_pending && aresetn) begin
    stack_mem[sp_inc] <= push_value; // [RQ10] [RQ14]
  end else if (wr_tos && !stack_empty && !fault_pending && aresetn) begin
    if (wr_top_entry_low) begin
      stack_mem[stack_pointer_value] <= {top_entry[20:8], w_data[7:0]}; // [RQ12]
    end else if (wr_top_entry_high) begin
      stack_mem[stack_pointer_value] <= {top_entry[20:16], w_data[7:0],
        top_entry[7:0]}; // [RQ12]
    end else begin
      stack_mem[stack_pointer_value] <= {w_data[4:0], top_entry[15:0]}; // [RQ12]
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// flags survive device reset; only power-on or software zero clears them
always @(posedge aclk) begin
  if (!por_n) begin
    stack_full_flag <= 1'b0; // [RQ17]
    stack_underflow_flag <= 1'b0; // [RQ17]
  end else begin
    // set beats a simultaneous software clear
    if (push_req && (push_will_fill || stack_at_top) && aresetn && !fault_pending) begin
      stack_full_flag <= 1'b1; // [RQ13] [RQ14]
    end else if (wr_status && !w_data[`PCRS_FULL_BIT]) begin
      stack_full_flag <= 1'b0; // [RQ17]
    end
    if (!push_req && pop_req && stack_empty && aresetn && !fault_pending) begin
      stack_underflow_flag <= 1'b1; // [RQ15]
    end else if (wr_status && !w_data[`PCRS_UNF_BIT]) begin
      stack_underflow_flag <= 1'b0; // [RQ17]
    end
  end
end

// shadow is hidden from software
always @(posedge aclk) begin
  if (!aresetn) begin
    shadow_status <= 8'h00;
    shadow_working <= 8'h00;
    shadow_bank <= 8'h00;
  end else if (irq_ack || (op_call && op_fast)) begin
    shadow_status <= status_in; // [RQ20] [RQ21]
    shadow_working <= working_register_in;
    shadow_bank <= bank_select_register_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// fault option comes from configuration outside this clock; three stages,
// and a change only counts once the last two agree, so a one-clock glitch is never seen
always @(posedge aclk) begin
  if (!aresetn) begin
    fault_en_meta <= `PCRS_CFG_RESET;
    fault_en_mid <= `PCRS_CFG_RESET;
    fault_en_late <= `PCRS_CFG_RESET;
    fault_enable <= `PCRS_CFG_RESET;
  end else begin
    fault_en_meta <= stack_fault_reset_enable;
    fault_en_mid <= fault_en_meta;
    fault_en_late <= fault_en_mid;
    if (fault_en_mid == fault_en_late) begin
      fault_enable <= fault_en_late; // [RQ16]
    end
  end
end

// fetch beyond the implemented memory decodes as a no-operation
always @(posedge aclk) begin
  if (!aresetn) begin
    fetch_data <= 16'h0000;
  end else begin
    fetch_data <= (pc > prog_mem_limit) ? 16'h0000 : fetch_data_in; // [RQ1]
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write path
always @(posedge aclk) begin
  if (!aresetn) begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h0000_0000;
    w_strb <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `PCRS_RESP_OKAY;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    if (wr_go) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known(aw_addr) ? `PCRS_RESP_OKAY : `PCRS_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read path
// read word is chosen combinationally, then registered, so rdata never glitches
always @* begin
  rd_value = 32'h0000_0000;
  rd_bad = 1'b0;
  case (s_axi_araddr)
    `PCRS_ADDR_STATUS: begin
      rd_value = {24'h00_0000, stack_full_flag, stack_underflow_flag, 1'b0,
        stack_pointer_value}; // [RQ19]
    end
    `PCRS_ADDR_PCL: begin
      rd_value = {24'h00_0000, pc_low_byte};
    end
    `PCRS_ADDR_LATH: begin
      rd_value = {24'h00_0000, pc_high_holding_latch};
    end
    `PCRS_ADDR_LATU: begin
      rd_value = {27'h000_0000, pc_upper_holding_latch};
    end
    `PCRS_ADDR_TOP_ENTRY_LOW: begin
      rd_value = {24'h00_0000, top_entry[7:0]}; // [RQ12]
    end
    `PCRS_ADDR_TOP_ENTRY_HIGH: begin
      rd_value = {24'h00_0000, top_entry[15:8]};
    end
    `PCRS_ADDR_TOP_ENTRY_UPPER: begin
      rd_value = {27'h000_0000, top_entry[20:16]};
    end
    `PCRS_ADDR_CFG: begin
      rd_value = {31'h0000_0000, fault_enable};
    end
    default: begin
      rd_bad = 1'b1;
    end
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `PCRS_RESP_OKAY;
  end else if (rd_go) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata <= rd_value;
    s_axi_rresp <= rd_bad ? `PCRS_RESP_SLVERR : `PCRS_RESP_OKAY;
  end else if (s_axi_rvalid && s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

endmodule

// ### include/pcrs_map.vh
`ifndef PCRS_MAP_VH
`define PCRS_MAP_VH
// axi4-lite register byte addresses
`define PCRS_ADDR_STATUS 8'h00
`define PCRS_ADDR_PCL 8'h04
`define PCRS_ADDR_LATH 8'h08
`define PCRS_ADDR_LATU 8'h0c
`define PCRS_ADDR_TOP_ENTRY_LOW 8'h10
`define PCRS_ADDR_TOP_ENTRY_HIGH 8'h14
`define PCRS_ADDR_TOP_ENTRY_UPPER 8'h18
`define PCRS_ADDR_CFG 8'h1c
`define PCRS_ADDR_PC 8'h20
// stack pointer register fields
`define PCRS_FULL_BIT 7
`define PCRS_UNF_BIT 6
`define PCRS_SP_MSB 4
// vectors and constants
`define PCRS_RESET_VEC 21'h00_0000
`define PCRS_HIGH_VEC 21'h00_0008
`define PCRS_LOW_VEC 21'h00_0018
`define PCRS_PC_STEP 21'h00_0002
`define PCRS_SP_EMPTY 5'h00
`define PCRS_SP_LAST 5'h1f
`define PCRS_SP_ONE 5'h01
`define PCRS_DEPTH 32
`define PCRS_CFG_RESET 1'b1
`define PCRS_RESP_OKAY 2'b00
`define PCRS_RESP_SLVERR 2'b10
`endif

// ### tb/pcrs_assertions.sv
`timescale 1ns/100ps
`include "pcrs_map.vh"
module pcrs_assertions (
  input wire aclk,
  input wire aresetn,
  input wire stack_fault_reset_enable,
  input wire [20:0] prog_mem_limit,
  input wire op_fast,
  input wire op_jump,
  input wire [20:0] jump_target,
  input wire op_return,
  input wire op_interrupt_return,
  input wire irq_ack,
  input wire irq_high,
  input wire [15:0] fetch_data,
  input wire [20:0] pc,
  input wire restore_valid,
  input wire device_reset_req,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_even; pc[0] == 1'b0; endproperty
  a_even: assert property (p_even) else $error("pc odd");
  property p_nop; pc > prog_mem_limit |=> fetch_data == 16'h0000; endproperty
  a_nop: assert property (p_nop) else $error("fetch above limit not zero");
  property p_vec; irq_ack |=> pc == ($past(irq_high) ? `PCRS_HIGH_VEC : `PCRS_LOW_VEC);
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  // a jump loses to an interrupt in the same cycle
  property p_jmp; op_jump && !irq_ack |=> pc == ($past(jump_target) & 21'h1f_fffe); endproperty
  a_jmp: assert property (p_jmp) else $error("jump target not loaded");
  property p_flt; device_reset_req |-> $past(stack_fault_reset_enable) ##[0:1] pc == 21'h00_0000;
  endproperty
  a_flt: assert property (p_flt) else $error("fault reset wrong");
  property p_pls; device_reset_req |=> !device_reset_req; endproperty
  a_pls: assert property (p_pls) else $error("fault request too long");
  property p_rst; restore_valid |-> $past(op_fast) && ($past(op_return) || $past(op_interrupt_return));
  endproperty
  a_rst: assert property (p_rst) else $error("restore without fast return");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken while answer pending");
endmodule
bind pcrs_core pcrs_assertions pcrs_assertions_inst (.aclk, .aresetn, .stack_fault_reset_enable,
  .prog_mem_limit, .op_fast, .op_jump, .jump_target, .op_return, .op_interrupt_return, .irq_ack,
  .irq_high, .fetch_data, .pc, .restore_valid, .device_reset_req, .s_axi_arready, .s_axi_rvalid);

// ### tb/pcrs_exec_model.sv
`timescale 1ns/100ps
module pcrs_exec_model (
  input wire aclk,
  input wire go,
  input wire [3:0] cmd,
  input wire fast,
  input wire [20:0] pc,
  output reg fetch_advance,
  output reg op_call,
  output reg op_fast,
  output reg op_jump,
  output reg op_return,
  output reg op_literal_return,
  output reg op_interrupt_return,
  output reg op_sw_push,
  output reg op_sw_pop,
  output reg irq_ack,
  output wire [20:0] fetch_return_addr
);
  // the pushed address is the instruction after the current one
  assign fetch_return_addr = pc + 21'h00_0002;
  // one pulse per command; interrupts only on request, so never during top entry access
  always @(posedge aclk) begin
    {irq_ack, op_sw_pop, op_sw_push, op_interrupt_return, op_literal_return, op_return, op_jump,
      op_call, fetch_advance} <= go ? (9'h001 << cmd) : 9'h000;
    op_fast <= go & fast;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`include "pcrs_map.vh"
module tb;
  reg aclk = 0, aresetn = 0, por_n = 0, go = 0, fast = 0, irq_high = 0;
  reg stack_fault_reset_enable = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  reg [3:0] cmd = 0;
  reg [20:0] jump_target = 0, e = 0;
  reg [7:0] status_in = 0, working_register_in = 0, bank_select_register_in = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [15:0] fetch_data_in = 0;
  reg [31:0] s_axi_wdata = 0, rdv = 0, rnd = 0;
  reg [23:0] sh = 0;
  reg [1:0] rsp = 0;
  wire fetch_advance, op_call, op_fast, op_jump, op_return, op_literal_return, op_sw_push;
  wire op_interrupt_return, op_sw_pop, irq_ack, restore_valid, device_reset_req, s_axi_bvalid;
  wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [20:0] pc, fetch_return_addr;
  wire [15:0] fetch_data;
  wire [7:0] status_restore, working_restore, bank_restore;
  integer n_errors = 0, num_checks = 0, seed = 49, i = 0;
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) fetch_data_in <= $random(seed);
  pcrs_exec_model pcrs_exec_model_inst (.aclk, .go, .cmd, .fast, .pc, .fetch_advance, .op_call,
    .op_fast, .op_jump, .op_return, .op_literal_return, .op_interrupt_return, .op_sw_push,
    .op_sw_pop, .irq_ack, .fetch_return_addr);
  pcrs_core pcrs_core_inst (.aclk, .aresetn, .por_n, .stack_fault_reset_enable,
    .prog_mem_limit(21'h00_1fff), .fetch_advance, .fetch_return_addr, .op_call, .op_fast, .op_jump,
    .jump_target, .op_return, .op_literal_return, .op_interrupt_return, .op_sw_push, .op_sw_pop,
    .irq_ack, .irq_high, .status_in, .working_register_in, .bank_select_register_in,
    .fetch_data_in, .fetch_data, .pc, .status_restore, .working_restore, .bank_restore,
    .restore_valid, .device_reset_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1));
  ////////////////////////////////////////////////////////////////////////////////
  function [20:0] f_vec(input h);
    f_vec = h ? `PCRS_HIGH_VEC : `PCRS_LOW_VEC;
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // fresh operands on every op so the shadow sees changing values
  task op(input [3:0] c, input f);
    begin
      rnd = $random(seed);
      cmd <= c; fast <= f; go <= 1; jump_target <= rnd[20:0];
      {status_in, working_register_in, bank_select_register_in} <= rnd[31:8] ^ 24'h5a_a55a;
      @(posedge aclk) go <= 0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw;
    begin
      ta = 0; tw = 0;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      while (!(ta && tw)) begin
        @(posedge aclk);
        ta = ta | (s_axi_awvalid & s_axi_awready);
        tw = tw | (s_axi_wvalid & s_axi_wready);
        if (ta) s_axi_awvalid <= 0;
        if (tw) s_axi_wvalid <= 0;
      end
      @(posedge aclk);
      while (!s_axi_bvalid) @(posedge aclk);
      rsp = s_axi_bresp;
    end
  endtask
  task rc(input [7:0] a, input [31:0] x);
    begin
      s_axi_araddr <= a; s_axi_arvalid <= 1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      rdv = s_axi_rdata; rsp = s_axi_rresp;
      chk(rdv, x);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1; por_n <= 1;
    @(posedge aclk);
    chk({11'h0, pc}, 0);
    rc(`PCRS_ADDR_STATUS, 0);
    for (i = 0; i < 3; i = i + 1) op(0, 0);
    chk({11'h0, pc}, 6);
    $display("done: reset and fetch");
    op(2, 0);
    e = (jump_target & 21'h1f_fffe) + 21'h00_0002;
    op(1, 0);
    chk({11'h0, pc}, {11'h0, jump_target & 21'h1f_fffe});
    rc(`PCRS_ADDR_STATUS, 1);
    rc(`PCRS_ADDR_TOP_ENTRY_LOW, e[7:0]);
    rc(`PCRS_ADDR_TOP_ENTRY_UPPER, e[20:16]);
    op(3, 0);
    chk({11'h0, pc}, {11'h0, e});
    op(3, 0);
    chk({11'h0, pc}, 0);
    rc(`PCRS_ADDR_STATUS, 32'h0000_0040);
    wr(`PCRS_ADDR_STATUS, 32'h0000_00c0);
    rc(`PCRS_ADDR_STATUS, 32'h0000_0040);
    wr(`PCRS_ADDR_STATUS, 0);
    rc(`PCRS_ADDR_STATUS, 0);
    $display("done: call return underflow");
    wr(`PCRS_ADDR_LATH, 32'h0000_0012);
    wr(`PCRS_ADDR_LATU, 32'h0000_0003);
    wr(`PCRS_ADDR_PCL, 32'h0000_0057);
    chk({11'h0, pc}, 32'h0003_1256);
    op(2, 0);
    rc(`PCRS_ADDR_PCL, jump_target[7:1] << 1);
    rc(`PCRS_ADDR_LATH, jump_target[15:8]);
    rc(`PCRS_ADDR_LATU, jump_target[20:16]);
    $display("done: latches");
    for (i = 0; i < 3; i = i + 1) begin
      irq_high <= (i == 0);
      op(2, 0);
      e = (jump_target & 21'h1f_fffe) + 21'h00_0002;
      op((i == 2) ? 4'h1 : 4'h8, i == 2);
      if (i < 2) chk({11'h0, pc}, {11'h0, f_vec(i == 0)});
      sh = {status_in, working_register_in, bank_select_register_in};
      op((i == 2) ? 4'h3 : 4'h5, 1'b1);
      chk({11'h0, pc}, {11'h0, e});
      chk({8'h0, status_restore, working_restore, bank_restore}, {8'h0, sh});
    end
    $display("done: interrupts and shadow");
    for (i = 0; i < 32; i = i + 1) op(6, 0);
    rc(`PCRS_ADDR_STATUS, 32'h0000_009f);
    wr(`PCRS_ADDR_STATUS, 32'h0000_0005);
    rc(`PCRS_ADDR_STATUS, 32'h0000_0005);
    op(7, 0);
    rc(`PCRS_ADDR_STATUS, 32'h0000_0004);
    stack_fault_reset_enable <= 1;
    wr(`PCRS_ADDR_STATUS, 32'h0000_001e);
    op(6, 0);
    rc(`PCRS_ADDR_STATUS, 32'h0000_0080);
    chk({11'h0, pc}, 0);
    rc(8'h40, 0);
    chk({30'h0, rsp}, {30'h0, `PCRS_RESP_SLVERR});
    $display("done: full, fault and unmapped");
    end_sim;
  end
endmodule
